// File: logic/ddcr_ctrl_if.sv
// Control bits passed from the register bank to its datapath and sync helpers
`timescale 1ns/1ps
interface ddcr_ctrl_if;
    logic compl_a;
    logic compl_b;
    logic coll_shut;
    logic coll_alarm_en;
    logic one_apart_en;
    logic two_apart_en;
    logic sw_sync_mode;
    logic sw_sync_bit;

    modport source (output compl_a, compl_b, coll_shut, coll_alarm_en, one_apart_en,
                    two_apart_en, sw_sync_mode, sw_sync_bit);
    modport sink (input compl_a, compl_b, coll_shut, coll_alarm_en, one_apart_en,
                  two_apart_en, sw_sync_mode, sw_sync_bit);
endinterface

// File: logic/ddcr_data_path.sv
// Converter word inversion, collision shutdown and FIFO alarm gating
`timescale 1ns/1ps
module ddcr_data_path #(
    parameter int DATA_W = 14
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    ddcr_ctrl_if.sink ctrl,
    input wire logic [DATA_W-1:0] dac_a_data_in,
    input wire logic [DATA_W-1:0] dac_b_data_in,
    input wire logic fifo_collision_in,
    input wire logic fifo_one_apart_in,
    input wire logic fifo_two_apart_in,
    output logic [DATA_W-1:0] dac_a_data_out,
    output logic [DATA_W-1:0] dac_b_data_out,
    output logic output_off_out,
    output logic collision_alarm_out,
    output logic one_apart_alarm_out,
    output logic two_apart_alarm_out
);
    import ddcr_pkg::*;

    // Refuse a word width the complement logic cannot serve
    if (DATA_W < 1)
    begin : g_bad_width
        $error("DATA_W must be at least 1");
    end

    // Complement swaps the analog pin roles without rewiring the board
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            dac_a_data_out <= '0;
            dac_b_data_out <= '0;
        end
        else
        begin
            dac_a_data_out <= ctrl.compl_a ? ~dac_a_data_in : dac_a_data_in;
            dac_b_data_out <= ctrl.compl_b ? ~dac_b_data_in : dac_b_data_in;
        end
    end

    // Alarm gating and shutdown request
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            output_off_out <= 1'b0;
            collision_alarm_out <= 1'b0;
            one_apart_alarm_out <= 1'b0;
            two_apart_alarm_out <= 1'b0;
        end
        else
        begin
            output_off_out <= ctrl.coll_shut & fifo_collision_in;
            collision_alarm_out <= ctrl.coll_alarm_en & fifo_collision_in;
            one_apart_alarm_out <= ctrl.one_apart_en & fifo_one_apart_in;
            two_apart_alarm_out <= ctrl.two_apart_en & fifo_two_apart_in;
        end
    end

    property p_invert_a;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        $past(ctrl.compl_a) |-> (dac_a_data_out ^ $past(dac_a_data_in)) == '1;
    endproperty
    a_invert_a: assert property (p_invert_a) else $error("channel a not inverted");

    property p_shutdown;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (fifo_collision_in && !ctrl.coll_shut) |=> !output_off_out;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown while disabled");

    property p_two_apart_gate;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !ctrl.two_apart_en |=> !two_apart_alarm_out;
    endproperty
    a_two_apart_gate: assert property (p_two_apart_gate) else $error("2-apart leaked");
endmodule

// File: logic/ddcr_pkg.sv
// Shared constants of the dual converter configuration register bank
package ddcr_pkg;
    // Bus and field widths
    localparam int AV_ADDR_W = 8;
    localparam int AV_DATA_W = 32;
    localparam int AV_BE_W = 4;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = AV_ADDR_W - IDX_LSB;
    localparam int REG_W = 16;
    localparam int LANE_W = 14;
    localparam int DLY_W = 3;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_OUT_ALARM = 6'h01;
    localparam logic [IDX_W-1:0] IDX_RX_EN = 6'h02;
    localparam logic [IDX_W-1:0] IDX_DELAY = 6'h03;
    localparam logic [IDX_W-1:0] IDX_PATTERN = 6'h04;

    // Reset values
    localparam logic [REG_W-1:0] RST_OUT_ALARM = 16'h600e;
    localparam logic [REG_W-1:0] RST_RX_EN = 16'h3fff;
    localparam logic [REG_W-1:0] RST_DELAY = 16'h0000;
    localparam logic [REG_W-1:0] RST_PATTERN = 16'h0000;

    // Implemented bits; everything else reads zero
    localparam logic [REG_W-1:0] MASK_OUT_ALARM = 16'hfefe;
    localparam logic [REG_W-1:0] MASK_RX_EN = 16'h3fff;
    localparam logic [REG_W-1:0] MASK_DELAY = 16'hfff9;
    localparam logic [REG_W-1:0] MASK_PATTERN = 16'h3fff;

    // Output and alarm control word
    localparam int BIT_IO_TEST = 15;
    localparam int BIT_B_SIDE_CLK = 14;
    localparam int BIT_FULL_WORD = 13;
    localparam int BIT_AUTO_CLEAR = 12;
    localparam int BIT_DAC_CLK_GONE = 11;
    localparam int BIT_DATA_CLK_GONE = 10;
    localparam int BIT_COLL_SHUT = 9;
    localparam int BIT_COMPL_A = 7;
    localparam int BIT_COMPL_B = 6;
    localparam int BIT_SW_SYNC = 5;
    localparam int BIT_SW_SYNC_MODE = 4;
    localparam int BIT_TWO_APART = 3;
    localparam int BIT_ONE_APART = 2;
    localparam int BIT_COLL_ALARM = 1;

    // Input delay word
    localparam int DLY_A_DATA_LSB = 13;
    localparam int DLY_A_CLK_LSB = 10;
    localparam int DLY_B_DATA_LSB = 7;
    localparam int DLY_B_CLK_LSB = 4;
    localparam int BIT_EXT_REF = 3;
    localparam int BIT_DUAL_CLK = 0;
    localparam int DELAY_STEP_PS = 80;
endpackage

// File: logic/ddcr_sync_select.sv
// Chip sync source selection: synchronised pin or register-driven edge
`timescale 1ns/1ps
module ddcr_sync_select (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    ddcr_ctrl_if.sink ctrl,
    input wire logic sync_input_pair_in,
    output logic chip_sync_out
);
    import ddcr_pkg::*;

    logic pin_meta;
    logic pin_sync;
    logic sw_bit_prev;

    // Pin crosses two flops before anything looks at it
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            pin_meta <= sync_input_pair_in;
            pin_sync <= pin_meta;
        end
    end

    // Tracks the bit in both modes so entering software mode never fakes an edge
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            sw_bit_prev <= 1'b0;
        else
            sw_bit_prev <= ctrl.sw_sync_bit;
    end

    // Source select; only a rising bit makes a pulse in software mode
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            chip_sync_out <= 1'b0;
        else if (ctrl.sw_sync_mode)
            chip_sync_out <= ctrl.sw_sync_bit & ~sw_bit_prev;
        else
            chip_sync_out <= pin_sync;
    end

    property p_sw_rise_pulse;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (ctrl.sw_sync_mode && ctrl.sw_sync_bit && !sw_bit_prev) |=> chip_sync_out;
    endproperty
    a_sw_rise_pulse: assert property (p_sw_rise_pulse) else $error("sync rise lost");

    property p_sw_fall_silent;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (ctrl.sw_sync_mode && $fell(ctrl.sw_sync_bit)) |=> !chip_sync_out;
    endproperty
    a_sw_fall_silent: assert property (p_sw_fall_silent) else $error("sync on fall");

    property p_pin_follow;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        ($past(!ctrl.sw_sync_mode) && !$past(sys_rst_in, 3))
            |-> chip_sync_out == $past(sync_input_pair_in, 3);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin sync wrong");
endmodule

// File: logic/ddcr_top.sv
// Dual converter configuration register bank on an Avalon-MM slave
`timescale 1ns/1ps
module ddcr_top (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic [ddcr_pkg::AV_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [ddcr_pkg::AV_DATA_W-1:0] avs_writedata_in,
    input wire logic [ddcr_pkg::AV_BE_W-1:0] avs_byteenable_in,
    output logic [ddcr_pkg::AV_DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [ddcr_pkg::LANE_W-1:0] dac_a_data_in,
    input wire logic [ddcr_pkg::LANE_W-1:0] dac_b_data_in,
    input wire logic fifo_collision_in,
    input wire logic fifo_one_apart_in,
    input wire logic fifo_two_apart_in,
    input wire logic [ddcr_pkg::LANE_W-1:0] pattern_error_in,
    input wire logic sync_input_pair_in,
    output logic [ddcr_pkg::LANE_W-1:0] dac_a_data_out,
    output logic [ddcr_pkg::LANE_W-1:0] dac_b_data_out,
    output logic output_off_out,
    output logic collision_alarm_out,
    output logic one_apart_alarm_out,
    output logic two_apart_alarm_out,
    output logic chip_sync_out,
    output logic [ddcr_pkg::LANE_W-1:0] receiver_enable_out,
    output logic [ddcr_pkg::DLY_W-1:0] port_a_lanes_delay_out,
    output logic [ddcr_pkg::DLY_W-1:0] port_a_clock_pair_delay_out,
    output logic [ddcr_pkg::DLY_W-1:0] port_b_lanes_delay_out,
    output logic [ddcr_pkg::DLY_W-1:0] port_b_clock_pair_delay_out,
    output logic ext_ref_select_out,
    output logic dual_clock_select_out,
    output logic full_word_mode_out,
    output logic io_test_enable_out,
    output logic b_side_clock_enable_out,
    output logic alarm_auto_clear_out,
    output logic dac_clock_gone_shut_out,
    output logic data_clock_gone_shut_out
);
    import ddcr_pkg::*;

    logic [REG_W-1:0] output_and_alarm_control;
    logic [REG_W-1:0] receiver_enable;
    logic [REG_W-1:0] input_delay_control;
    logic [REG_W-1:0] pattern_check_results;
    logic [REG_W-1:0] next_read_word;
    logic [REG_W-1:0] pattern_clear;
    logic [REG_W-1:0] pattern_set;
    logic [IDX_W-1:0] reg_index;
    logic bus_req;
    logic bus_ack;
    logic wr_en;
    logic rd_en;

    ddcr_ctrl_if ctrl ();

    // Byte-lane merge; unimplemented bits are forced to zero on the way in
    function automatic logic [REG_W-1:0] lane_merge(
        input logic [REG_W-1:0] old_val,
        input logic [AV_DATA_W-1:0] data,
        input logic [AV_BE_W-1:0] be,
        input logic [REG_W-1:0] mask
    );
        logic [REG_W-1:0] merged;
        merged = old_val;
        if (be[0])
            merged[7:0] = data[7:0];
        if (be[1])
            merged[15:8] = data[15:8];
        return merged & mask;
    endfunction

    // Bus decode; a request is taken when waitrequest is high and answered next cycle
    assign reg_index = avs_address_in[AV_ADDR_W-1:IDX_LSB];
    assign bus_req = avs_read_in | avs_write_in;
    assign bus_ack = bus_req & avs_waitrequest_out;
    assign wr_en = bus_ack & avs_write_in;
    assign rd_en = bus_ack & avs_read_in;

    // One wait state keeps readdata a flop and leaves the decode unhurried
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            avs_waitrequest_out <= 1'b1;
        else
            avs_waitrequest_out <= ~bus_ack;
    end

    // Output and alarm control word
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            output_and_alarm_control <= RST_OUT_ALARM;
        else if (wr_en && reg_index == IDX_OUT_ALARM)
            output_and_alarm_control <= lane_merge(output_and_alarm_control, avs_writedata_in,
                                                   avs_byteenable_in, MASK_OUT_ALARM);
    end

    // Receiver power word
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            receiver_enable <= RST_RX_EN;
        else if (wr_en && reg_index == IDX_RX_EN)
            receiver_enable <= lane_merge(receiver_enable, avs_writedata_in,
                                          avs_byteenable_in, MASK_RX_EN);
    end

    // Input delay word; dual clock is not interlocked with sync mode here
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            input_delay_control <= RST_DELAY;
        else if (wr_en && reg_index == IDX_DELAY)
            input_delay_control <= lane_merge(input_delay_control, avs_writedata_in,
                                              avs_byteenable_in, MASK_DELAY);
    end

    // Pattern results: write one to clear, a new error in the same cycle wins
    assign pattern_set = {{(REG_W-LANE_W){1'b0}}, pattern_error_in};
    assign pattern_clear = (wr_en && reg_index == IDX_PATTERN)
                         ? lane_merge('0, avs_writedata_in, avs_byteenable_in, MASK_PATTERN)
                         : '0;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            pattern_check_results <= RST_PATTERN;
        else
            pattern_check_results <= ((pattern_check_results & ~pattern_clear) | pattern_set)
                                     & MASK_PATTERN;
    end

    // Read selection; unmapped offsets read zero
    always_comb
    begin
        case (reg_index)
            IDX_OUT_ALARM: next_read_word = output_and_alarm_control;
            IDX_RX_EN: next_read_word = receiver_enable;
            IDX_DELAY: next_read_word = input_delay_control;
            IDX_PATTERN: next_read_word = pattern_check_results;
            default: next_read_word = '0;
        endcase
    end

    // Read data latched at the accepting edge, upper half always zero
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            avs_readdata_out <= '0;
        else if (rd_en)
            avs_readdata_out <= {{(AV_DATA_W-REG_W){1'b0}}, next_read_word};
    end

    // Control bits for the helpers
    assign ctrl.compl_a = output_and_alarm_control[BIT_COMPL_A];
    assign ctrl.compl_b = output_and_alarm_control[BIT_COMPL_B];
    assign ctrl.coll_shut = output_and_alarm_control[BIT_COLL_SHUT];
    assign ctrl.coll_alarm_en = output_and_alarm_control[BIT_COLL_ALARM];
    assign ctrl.one_apart_en = output_and_alarm_control[BIT_ONE_APART];
    assign ctrl.two_apart_en = output_and_alarm_control[BIT_TWO_APART];
    assign ctrl.sw_sync_mode = output_and_alarm_control[BIT_SW_SYNC_MODE];
    assign ctrl.sw_sync_bit = output_and_alarm_control[BIT_SW_SYNC];

    // Analog-side settings come straight off the register flops
    assign receiver_enable_out = receiver_enable[LANE_W-1:0];
    assign port_a_lanes_delay_out = input_delay_control[DLY_A_DATA_LSB +: DLY_W];
    assign port_a_clock_pair_delay_out = input_delay_control[DLY_A_CLK_LSB +: DLY_W];
    assign port_b_lanes_delay_out = input_delay_control[DLY_B_DATA_LSB +: DLY_W];
    assign port_b_clock_pair_delay_out = input_delay_control[DLY_B_CLK_LSB +: DLY_W];
    assign ext_ref_select_out = input_delay_control[BIT_EXT_REF];
    assign dual_clock_select_out = input_delay_control[BIT_DUAL_CLK];
    assign full_word_mode_out = output_and_alarm_control[BIT_FULL_WORD];
    assign io_test_enable_out = output_and_alarm_control[BIT_IO_TEST];
    assign b_side_clock_enable_out = output_and_alarm_control[BIT_B_SIDE_CLK];
    assign alarm_auto_clear_out = output_and_alarm_control[BIT_AUTO_CLEAR];
    assign dac_clock_gone_shut_out = output_and_alarm_control[BIT_DAC_CLK_GONE];
    assign data_clock_gone_shut_out = output_and_alarm_control[BIT_DATA_CLK_GONE];

    // Datapath: inversion, shutdown, alarm gating
    ddcr_data_path #(
        .DATA_W(LANE_W)
    ) u_data_path (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .ctrl(ctrl.sink),
        .dac_a_data_in(dac_a_data_in),
        .dac_b_data_in(dac_b_data_in),
        .fifo_collision_in(fifo_collision_in),
        .fifo_one_apart_in(fifo_one_apart_in),
        .fifo_two_apart_in(fifo_two_apart_in),
        .dac_a_data_out(dac_a_data_out),
        .dac_b_data_out(dac_b_data_out),
        .output_off_out(output_off_out),
        .collision_alarm_out(collision_alarm_out),
        .one_apart_alarm_out(one_apart_alarm_out),
        .two_apart_alarm_out(two_apart_alarm_out)
    );

    // Chip sync source
    ddcr_sync_select u_sync_select (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .ctrl(ctrl.sink),
        .sync_input_pair_in(sync_input_pair_in),
        .chip_sync_out(chip_sync_out)
    );

    // Bus handshake, register field, pattern and datapath checks
    property p_wait_single;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_wait_single: assert property (p_wait_single) else $error("waitrequest low too long");

    property p_wait_bounded;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (bus_req && avs_waitrequest_out) |=> !avs_waitrequest_out;
    endproperty
    a_wait_bounded: assert property (p_wait_bounded) else $error("request not answered");

    property p_read_upper_zero;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (avs_read_in && !avs_waitrequest_out)
            |-> avs_readdata_out[AV_DATA_W-1:REG_W] == '0
                && (reg_index != IDX_OUT_ALARM
                    || (avs_readdata_out[REG_W-1:0] & ~MASK_OUT_ALARM) == '0)
                && (reg_index != IDX_DELAY
                    || (avs_readdata_out[REG_W-1:0] & ~MASK_DELAY) == '0)
                && (reg_index != IDX_RX_EN
                    || (avs_readdata_out[REG_W-1:0] & ~MASK_RX_EN) == '0);
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero) else $error("reserved bit set");

    property p_rx_write;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (wr_en && reg_index == IDX_RX_EN && avs_byteenable_in[1:0] == 2'b11)
            |=> receiver_enable_out == $past(avs_writedata_in[LANE_W-1:0]);
    endproperty
    a_rx_write: assert property (p_rx_write) else $error("receiver enable not written");

    property p_delay_write;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (wr_en && reg_index == IDX_DELAY && avs_byteenable_in[1:0] == 2'b11)
            |=> port_a_lanes_delay_out == $past(avs_writedata_in[15:13])
                && port_b_clock_pair_delay_out == $past(avs_writedata_in[6:4])
                && dual_clock_select_out == $past(avs_writedata_in[0]);
    endproperty
    a_delay_write: assert property (p_delay_write) else $error("delay word not written");

    property p_delay_hold;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !(wr_en && reg_index == IDX_DELAY) |=> $stable(input_delay_control);
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("delay word changed alone");

    property p_pattern_set_wins;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (pattern_error_in != '0)
            |=> (pattern_check_results[LANE_W-1:0] & $past(pattern_error_in))
                == $past(pattern_error_in);
    endproperty
    a_pattern_set_wins: assert property (p_pattern_set_wins) else $error("pattern error lost");

    property p_coll_alarm_path;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (fifo_collision_in && ctrl.coll_alarm_en) |=> collision_alarm_out;
    endproperty
    a_coll_alarm_path: assert property (p_coll_alarm_path) else $error("collision alarm lost");

    property p_one_apart_gate;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        one_apart_alarm_out |-> $past(fifo_one_apart_in && ctrl.one_apart_en);
    endproperty
    a_one_apart_gate: assert property (p_one_apart_gate) else $error("1-apart alarm wrong");

    property p_invert_b;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        $past(!ctrl.compl_b) |-> dac_b_data_out == $past(dac_b_data_in);
    endproperty
    a_invert_b: assert property (p_invert_b) else $error("channel b altered");

    property p_ext_ref_bit;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (wr_en && reg_index == IDX_DELAY && avs_byteenable_in[0])
            |=> ext_ref_select_out == $past(avs_writedata_in[3]);
    endproperty
    a_ext_ref_bit: assert property (p_ext_ref_bit) else $error("reference select wrong");

    // A full clear with no new error must leave the written bits at zero
    property p_pattern_clear;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (wr_en && reg_index == IDX_PATTERN && avs_byteenable_in[1:0] == 2'b11
            && pattern_error_in == '0)
            |=> (pattern_check_results & $past(avs_writedata_in[REG_W-1:0])) == '0;
    endproperty
    a_pattern_clear: assert property (p_pattern_clear) else $error("pattern bit not cleared");

    property p_alarm_en_wr;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (wr_en && reg_index == IDX_OUT_ALARM && avs_byteenable_in[0])
            |=> {ctrl.two_apart_en, ctrl.one_apart_en, ctrl.coll_alarm_en}
                == $past(avs_writedata_in[BIT_TWO_APART:BIT_COLL_ALARM]);
    endproperty
    a_alarm_en_wr: assert property (p_alarm_en_wr) else $error("enable lost");

    property p_sync_mode_wr;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (wr_en && reg_index == IDX_OUT_ALARM && avs_byteenable_in[0])
            |=> ctrl.sw_sync_mode == $past(avs_writedata_in[BIT_SW_SYNC_MODE]);
    endproperty
    a_sync_mode_wr: assert property (p_sync_mode_wr) else $error("sync mode lost");

    property p_full_word_wr;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (wr_en && reg_index == IDX_OUT_ALARM && avs_byteenable_in[1])
            |=> full_word_mode_out == $past(avs_writedata_in[BIT_FULL_WORD]);
    endproperty
    a_full_word_wr: assert property (p_full_word_wr) else $error("bus mode lost");

    property p_clk_delay_wr;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (wr_en && reg_index == IDX_DELAY && avs_byteenable_in[1:0] == 2'b11)
            |=> port_a_clock_pair_delay_out == $past(avs_writedata_in[DLY_A_CLK_LSB +: DLY_W])
                && port_b_lanes_delay_out == $past(avs_writedata_in[DLY_B_DATA_LSB +: DLY_W]);
    endproperty
    a_clk_delay_wr: assert property (p_clk_delay_wr) else $error("delay lost");

    // Receiver power must not drift between writes
    property p_rx_hold;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !(wr_en && reg_index == IDX_RX_EN) |=> $stable(receiver_enable);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receiver word changed");

    // Main scenarios
    c_write_accept: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        avs_write_in && !avs_waitrequest_out);
    c_sw_sync_pulse: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ctrl.sw_sync_mode ##1 chip_sync_out);
    c_shutdown: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        output_off_out);
    c_pattern_clear: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (pattern_check_results != '0) ##1 (pattern_check_results == '0));
    c_set_wins: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (pattern_error_in != '0) && (pattern_clear != '0));
endmodule

// File: tb/test_ddcr_top.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h", $time, g); end end
module test_ddcr_top;
    import ddcr_pkg::*;
    logic clk = 0, rst = 1, rd = 0, wr = 0, col = 0, one = 0, two = 0, pin = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, q, rdat;
    logic [13:0] da = 14'h0, db = 14'h0, ao, bo, rx;
    logic [2:0] d0, d1, d2, d3;
    logic w, off, ca, oa, ta, cs, er, dc, fw;
    logic [4:0] xo;
    logic [13:0] pe = 14'h0;
    int n_mismatch = 0, checked = 0, ns = 0;
    ddcr_top ddcr_top_i (.sys_clk_in(clk), .sys_rst_in(rst), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'h3),
        .avs_readdata_out(q), .avs_waitrequest_out(w), .dac_a_data_in(da), .dac_b_data_in(db),
        .fifo_collision_in(col), .fifo_one_apart_in(one), .fifo_two_apart_in(two),
        .pattern_error_in(pe), .sync_input_pair_in(pin), .dac_a_data_out(ao),
        .dac_b_data_out(bo), .output_off_out(off), .collision_alarm_out(ca),
        .one_apart_alarm_out(oa), .two_apart_alarm_out(ta), .chip_sync_out(cs),
        .receiver_enable_out(rx), .port_a_lanes_delay_out(d0), .port_a_clock_pair_delay_out(d1),
        .port_b_lanes_delay_out(d2), .port_b_clock_pair_delay_out(d3), .ext_ref_select_out(er),
        .dual_clock_select_out(dc), .full_word_mode_out(fw), .io_test_enable_out(xo[4]),
        .b_side_clock_enable_out(xo[3]), .alarm_auto_clear_out(xo[2]),
        .dac_clock_gone_shut_out(xo[1]), .data_clock_gone_shut_out(xo[0]));
    // Clock, and a sync pulse counter so pulse timing need not be guessed
    initial forever #50 clk = ~clk;
    always @(negedge clk) if (cs === 1'b1) ns++;
    // One bus cycle; request held until waitrequest is seen low
    task bus(input logic r, input logic [7:0] a, input logic [15:0] d);
        adr <= a;
        wd <= {16'h0, d};
        rd <= r;
        wr <= !r;
        do @(posedge clk); while (w !== 1'b0);
        rdat = q;
        rd <= 0;
        wr <= 0;
        @(posedge clk);
    endtask
    task t_reset;
        bus(1, 8'h04, 16'h0); `CHK(rdat, 32'h600e)
        `CHK({fw, xo}, 6'h28)
        bus(1, 8'h08, 16'h0); `CHK(rdat, 32'h3fff)
        bus(1, 8'h0c, 16'h0); `CHK({d0, d1, d2, d3, er, dc, rdat}, 46'h0)
    endtask
    task t_regs;
        bus(0, 8'h04, 16'h0010); // Sync mode before dual clocks
        bus(0, 8'h0c, 16'haf9f);
        bus(1, 8'h0c, 16'h0); `CHK(rdat, 32'haf99)
        `CHK({d0, d1, d2, d3}, 12'haf9)
        `CHK({er, dc}, 2'h3)
        bus(0, 8'h08, 16'hd5a5);
        bus(1, 8'h08, 16'h0); `CHK(rdat, 32'h15a5)
        `CHK(rx, 14'h15a5)
        bus(0, 8'h20, 16'h1234); // Unmapped place
        bus(1, 8'h20, 16'h0); `CHK(rdat, 32'h0)
    endtask
    task t_data;
        da <= 14'h1234;
        db <= 14'h2bcd;
        {col, one, two} <= 3'h7;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            bus(0, 8'h04, i ? 16'h02ce : 16'h0000);
            @(negedge clk);
            `CHK(ao, 14'h1234 ^ {14{i[0]}})
            `CHK(bo, 14'h2bcd ^ {14{i[0]}})
            `CHK({off, ca, oa, ta}, {4{i[0]}})
        end
        @(posedge clk) col <= 0;
        repeat (2) @(posedge clk);
        @(negedge clk) `CHK({off, ca}, 2'h0)
        @(posedge clk);
    endtask
    task t_sync;
        int n0;
        bus(0, 8'h04, 16'h0000);
        pin <= 1;
        repeat (5) @(posedge clk);
        @(negedge clk) `CHK(cs, 1'b1)
        @(posedge clk) pin <= 0;
        repeat (5) @(posedge clk);
        bus(0, 8'h04, 16'h0010);
        n0 = ns;
        pin <= 1;
        repeat (5) @(posedge clk);
        `CHK(ns, n0)
        bus(0, 8'h04, 16'h0030);
        repeat (3) @(posedge clk);
        `CHK(ns, n0 + 1)
        bus(0, 8'h04, 16'h0010);
        repeat (3) @(posedge clk);
        `CHK(ns, n0 + 1)
        bus(0, 8'h04, 16'h0030);
        repeat (3) @(posedge clk);
        `CHK(ns, n0 + 2)
    endtask
    // Error bits latch, clear on a one, and a new error beats the clear
    task t_pat;
        pe <= 14'h2481;
        @(posedge clk) pe <= 14'h0;
        bus(1, 8'h10, 16'h0); `CHK(rdat, 32'h2481)
        pe <= 14'h0100;
        bus(0, 8'h10, 16'hffff);
        pe <= 14'h0;
        bus(1, 8'h10, 16'h0); `CHK(rdat, 32'h0100)
        bus(0, 8'h10, 16'hffff);
        bus(1, 8'h10, 16'h0); `CHK(rdat, 32'h0)
    endtask
    task final_report;
        if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence, and a watchdog far beyond the hundred or so cycles needed
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_reset;
        t_regs;
        t_data;
        t_sync;
        t_pat;
        final_report;
    end
    initial
    begin
        #1000000;
        n_mismatch++;
        final_report;
    end
endmodule
